// File: rtl/swel_pkg.sv
// Function
// - The block holds one of three sleep states (S3, S4, S5) or working, and wake checks depend on it.
// - In S3, S4 or S5 the power button, SMBus alert, PCIe wake and watchdog button event always wake.
// - The general wake input wakes only from S3 and is ignored in S4 and S5.
// - PME wakes only when the device PME enable or the global resume-on-PME enable is set.
// - The RTC alarm wakes only when its resume is enabled and configured, and only from S5.
// - A USB event wakes from S3 or S4 only when USB wakeup is enabled and the device may wake.
// - A USB wake from S3 also needs the USB detect logic to be on standby power.
// - A LAN event wakes only when wake-on-LAN is configured, otherwise it is ignored.
// - Inputs whose names end in _n are asserted low and all others are asserted high.
package swel_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ENABLE   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h10;

    // wake source indices
    localparam int NSRC     = 9;
    localparam int SRC_PWRBTN = 0;
    localparam int SRC_SMBALR = 1;
    localparam int SRC_PCIEWK = 2;
    localparam int SRC_WDTBTN = 3;
    localparam int SRC_GENWK  = 4;
    localparam int SRC_PME    = 5;
    localparam int SRC_LAN    = 6;
    localparam int SRC_USB    = 7;
    localparam int SRC_RTC    = 8;

    // sources whose pin is asserted low
    localparam logic [NSRC-1:0] SRC_ACT_LOW = 9'h037;

    // enable register fields
    localparam int EN_LAN_WOL   = 0;
    localparam int EN_PME_GLOB  = 1;
    localparam int EN_PME_DEV   = 2;
    localparam int EN_USB_WAKE  = 3;
    localparam int EN_USB_ALLOW = 4;
    localparam int EN_RTC_RES   = 5;
    localparam int EN_RTC_CFG   = 6;
    localparam int EN_W         = 7;

    // control register sleep request codes
    localparam logic [1:0] CODE_WORK = 2'h0;
    localparam logic [1:0] CODE_S3   = 2'h1;
    localparam logic [1:0] CODE_S4   = 2'h2;
    localparam logic [1:0] CODE_S5   = 2'h3;

    // status register fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_SRC_LSB   = 4;
    localparam int ST_LVL_LSB   = 16;

    // interrupt status layout: one bit per source, then sleep entry
    localparam int INT_W     = 10;
    localparam int INT_SLEEP = 9;

    // values after reset
    localparam logic [EN_W-1:0]   RST_ENABLE   = 7'h00;
    localparam logic [INT_W-1:0]  RST_INT_MASK = 10'h000;
    localparam logic [NSRC-1:0]   RST_SRC      = 9'h000;
    localparam logic [DATA_W-1:0] RST_RDATA    = 32'h0000_0000;

    // power states
    typedef enum logic [1:0] {
        SWEL_WORK,
        SWEL_S3,
        SWEL_S4,
        SWEL_S5
    } swel_state_t;

endpackage : swel_pkg

// File: rtl/swel_edge.sv
`timescale 1ns/100ps
module swel_edge (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic [swel_pkg::NSRC-1:0] pins,
    output logic      [swel_pkg::NSRC-1:0] asserted,
    output logic      [swel_pkg::NSRC-1:0] rise
);
    import swel_pkg::*;

    typedef struct packed {
        logic [NSRC-1:0] prev;
    } swel_edge_st_t;

    swel_edge_st_t st_reg;
    swel_edge_st_t st_next;

    // fold pin polarity into one asserted-high vector
    for (genvar i = 0; i < NSRC; i++) begin : g_pol
        assign asserted[i] = SRC_ACT_LOW[i] ? ~pins[i] : pins[i];
    end

    // a held level counts once, only on its leading edge
    assign rise = asserted & ~st_reg.prev;

    // next state
    always_comb begin
        st_next      = st_reg;
        st_next.prev = asserted;
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg.prev <= RST_SRC;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

endmodule : swel_edge

// File: rtl/swel_core.sv
`timescale 1ns/100ps
module swel_core (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        ce,
    // register port
    input  wire logic [swel_pkg::ADDR_W-1:0] addr,
    input  wire logic [swel_pkg::DATA_W-1:0] wr_data,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic      [swel_pkg::DATA_W-1:0] rd_data,
    // wake inputs
    input  wire logic                        pwrbtn_n,
    input  wire logic                        smb_alert_n,
    input  wire logic                        pcie_wake_n,
    input  wire logic                        wdt_pwrbtn,
    input  wire logic                        gen_wake_n,
    input  wire logic                        pme_n,
    input  wire logic                        lan_wake,
    input  wire logic                        usb_wake,
    input  wire logic                        rtc_alarm,
    input  wire logic                        usb_on_standby,
    // state and event outputs
    output logic                             sleep_s3_n,
    output logic                             sleep_s4_n,
    output logic                             sleep_s5_n,
    output logic                             wake_pulse,
    output logic      [swel_pkg::NSRC-1:0]   wake_src,
    output logic                             irq
);
    import swel_pkg::*;

    // whole state of the block
    typedef struct packed {
        swel_state_t       state;
        logic [EN_W-1:0]   enable;
        logic [INT_W-1:0]  int_stat;
        logic [INT_W-1:0]  int_mask;
        logic [NSRC-1:0]   last_src;
        logic              wake_pulse;
        logic [2:0]        sleep_n;
        logic [DATA_W-1:0] rdata;
    } swel_st_t;

    swel_st_t st_reg;
    swel_st_t st_next;

    logic [NSRC-1:0] pins;
    logic [NSRC-1:0] asserted;
    logic [NSRC-1:0] rise;
    logic [NSRC-1:0] qual;
    logic [NSRC-1:0] first;
    logic            any_wake;
    logic            sleep_req;
    logic [1:0]      req_code;

    // code of a power state as software sees it
    function automatic logic [1:0] swel_code(input swel_state_t s);
        logic [1:0] c;
        c = CODE_WORK;
        unique case (s)
            SWEL_WORK: c = CODE_WORK;
            SWEL_S3:   c = CODE_S3;
            SWEL_S4:   c = CODE_S4;
            SWEL_S5:   c = CODE_S5;
        endcase
        return c;
    endfunction : swel_code

    // power state for a requested code
    function automatic swel_state_t swel_decode(input logic [1:0] c);
        swel_state_t s;
        s = SWEL_WORK;
        unique case (c)
            CODE_WORK: s = SWEL_WORK;
            CODE_S3:   s = SWEL_S3;
            CODE_S4:   s = SWEL_S4;
            CODE_S5:   s = SWEL_S5;
        endcase
        return s;
    endfunction : swel_decode

    // active-low sleep pins for a state
    function automatic logic [2:0] swel_pins(input swel_state_t s);
        logic [2:0] p;
        p    = 3'h7;
        p[0] = (s != SWEL_S3);
        p[1] = (s != SWEL_S4);
        p[2] = (s != SWEL_S5);
        return p;
    endfunction : swel_pins

    // gather the wake pins in source order
    always_comb begin
        pins             = '0;
        pins[SRC_PWRBTN] = pwrbtn_n;
        pins[SRC_SMBALR] = smb_alert_n;
        pins[SRC_PCIEWK] = pcie_wake_n;
        pins[SRC_WDTBTN] = wdt_pwrbtn;
        pins[SRC_GENWK]  = gen_wake_n;
        pins[SRC_PME]    = pme_n;
        pins[SRC_LAN]    = lan_wake;
        pins[SRC_USB]    = usb_wake;
        pins[SRC_RTC]    = rtc_alarm;
    end

    // polarity and edge detection of all wake sources
    swel_edge u_edge (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .pins     (pins),
        .asserted (asserted),
        .rise     (rise)
    );

    // qualify each wake edge against the state and its enables
    always_comb begin
        qual = '0;
        if (st_reg.state != SWEL_WORK) begin
            // unconditional in any sleep state
            qual[SRC_PWRBTN] = rise[SRC_PWRBTN];
            qual[SRC_SMBALR] = rise[SRC_SMBALR];
            qual[SRC_PCIEWK] = rise[SRC_PCIEWK];
            qual[SRC_WDTBTN] = rise[SRC_WDTBTN];
            // general wake only from suspend-to-RAM
            qual[SRC_GENWK]  = rise[SRC_GENWK] && (st_reg.state == SWEL_S3);
            // either PME enable suffices
            qual[SRC_PME]    = rise[SRC_PME]
                               && (st_reg.enable[EN_PME_GLOB]
                                   || st_reg.enable[EN_PME_DEV]);
            // LAN needs wake-on-LAN configured
            qual[SRC_LAN]    = rise[SRC_LAN] && st_reg.enable[EN_LAN_WOL];
            // USB from S3 or S4 with both enables
            qual[SRC_USB]    = rise[SRC_USB]
                               && st_reg.enable[EN_USB_WAKE]
                               && st_reg.enable[EN_USB_ALLOW]
                               && ((st_reg.state == SWEL_S3 && usb_on_standby)
                                   || st_reg.state == SWEL_S4);
            // RTC alarm only from soft-off, enabled and configured
            qual[SRC_RTC]    = rise[SRC_RTC]
                               && st_reg.enable[EN_RTC_RES]
                               && st_reg.enable[EN_RTC_CFG]
                               && (st_reg.state == SWEL_S5);
        end
    end

    // lowest index wins when several sources wake together
    always_comb begin
        first = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (qual[i]) begin
                first    = '0;
                first[i] = 1'b1;
            end
        end
    end

    assign any_wake  = |qual;
    assign req_code  = wr_data[1:0];
    assign sleep_req = wr_en && (addr == OFS_CTRL) && (req_code != CODE_WORK);

    // next state of the whole block
    always_comb begin
        logic [INT_W-1:0] set;
        logic [INT_W-1:0] clr;
        st_next            = st_reg;
        set                = '0;
        clr                = '0;
        st_next.wake_pulse = 1'b0;

        // power state sequencing
        unique case (st_reg.state)
            SWEL_WORK: begin
                // software enters a sleep state from working only
                if (sleep_req) begin
                    st_next.state      = swel_decode(req_code);
                    set[INT_SLEEP]     = 1'b1;
                end
            end
            SWEL_S3, SWEL_S4, SWEL_S5: begin
                // a qualified source returns to working
                if (any_wake) begin
                    st_next.state      = SWEL_WORK;
                    st_next.wake_pulse = 1'b1;
                    st_next.last_src   = first;
                    set[NSRC-1:0]      = first;
                end
            end
        endcase

        // registered sleep pins follow the next state
        st_next.sleep_n = swel_pins(st_next.state);

        // register writes
        if (wr_en) begin
            unique case (addr)
                OFS_ENABLE:   st_next.enable   = wr_data[EN_W-1:0];
                OFS_INT_MASK: st_next.int_mask = wr_data[INT_W-1:0];
                default: ;
            endcase
        end

        // register reads, data valid the cycle after the strobe
        st_next.rdata = RST_RDATA;
        if (rd_en) begin
            unique case (addr)
                OFS_CTRL: begin
                    st_next.rdata[1:0] = swel_code(st_reg.state);
                end
                OFS_ENABLE: begin
                    st_next.rdata[EN_W-1:0] = st_reg.enable;
                end
                OFS_STATUS: begin
                    st_next.rdata[ST_STATE_LSB +: 2]  = swel_code(st_reg.state);
                    st_next.rdata[ST_SRC_LSB +: NSRC] = st_reg.last_src;
                    st_next.rdata[ST_LVL_LSB +: NSRC] = asserted;
                end
                OFS_INT_STAT: begin
                    st_next.rdata[INT_W-1:0] = st_reg.int_stat;
                    clr                      = st_reg.int_stat;
                end
                OFS_INT_MASK: begin
                    st_next.rdata[INT_W-1:0] = st_reg.int_mask;
                end
                default: ;
            endcase
        end

        // sticky events; a new event beats the read clear
        st_next.int_stat = (st_reg.int_stat & ~clr) | set;
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg.state      <= SWEL_WORK;
            st_reg.enable     <= RST_ENABLE;
            st_reg.int_stat   <= '0;
            st_reg.int_mask   <= RST_INT_MASK;
            st_reg.last_src   <= RST_SRC;
            st_reg.wake_pulse <= 1'b0;
            st_reg.sleep_n    <= 3'h7;
            st_reg.rdata      <= RST_RDATA;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign rd_data    = st_reg.rdata;
    assign sleep_s3_n = st_reg.sleep_n[0];
    assign sleep_s4_n = st_reg.sleep_n[1];
    assign sleep_s5_n = st_reg.sleep_n[2];
    assign wake_pulse = st_reg.wake_pulse;
    assign wake_src   = st_reg.last_src;

    // level interrupt while any unmasked event is pending
    assign irq = |(st_reg.int_stat & st_reg.int_mask);

endmodule : swel_core

// File: bench/swel_wake_src.sv
`timescale 1ns/100ps
module swel_wake_src (
    act,
    pins
);
    import swel_pkg::*;
    input  wire logic [swel_pkg::NSRC-1:0] act;
    output logic      [swel_pkg::NSRC-1:0] pins;
    // button, alert, pcie, general wake and pme pins are low when asserted
    assign pins = act ^ 9'h037;
endmodule : swel_wake_src

// File: bench/swel_core_props.sv
`timescale 1ns/100ps
module swel_core_props (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic                      ce,
    input wire logic                      pwrbtn_n,
    input wire logic                      usb_on_standby,
    input wire logic                      sleep_s3_n,
    input wire logic                      sleep_s4_n,
    input wire logic                      sleep_s5_n,
    input wire logic                      wake_pulse,
    input wire logic [swel_pkg::NSRC-1:0] wake_src
);
    import swel_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // high while any sleep state is held
    wire slp = !(sleep_s3_n && sleep_s4_n && sleep_s5_n);
    // state and wake source relations
    property p_one_state; $onehot0(~{sleep_s3_n, sleep_s4_n, sleep_s5_n}); endproperty
    a_one_state: assert property (p_one_state) else $error("two sleep states");
    property p_work_quiet; !slp |=> !wake_pulse && $stable(wake_src); endproperty
    a_work_quiet: assert property (p_work_quiet) else $error("wake while working");
    property p_from_sleep; wake_pulse |-> $past(slp) && !slp && $onehot(wake_src); endproperty
    a_from_sleep: assert property (p_from_sleep) else $error("bad wake exit");
    property p_gen_s3; wake_pulse && wake_src[SRC_GENWK] |-> !$past(sleep_s3_n); endproperty
    a_gen_s3: assert property (p_gen_s3) else $error("general wake outside S3");
    property p_rtc_s5; wake_pulse && wake_src[SRC_RTC] |-> !$past(sleep_s5_n); endproperty
    a_rtc_s5: assert property (p_rtc_s5) else $error("alarm wake outside S5");
    property p_usb_s3s4;
        wake_pulse && wake_src[SRC_USB] |-> !($past(sleep_s3_n) && $past(sleep_s4_n));
    endproperty
    a_usb_s3s4: assert property (p_usb_s3s4) else $error("usb wake from S5");
    property p_usb_sb;
        wake_pulse && wake_src[SRC_USB] && !$past(sleep_s3_n) |-> $past(usb_on_standby);
    endproperty
    a_usb_sb: assert property (p_usb_sb) else $error("usb wake off standby");
    property p_btn_wake;
        slp && ce && $past(ce) && $fell(pwrbtn_n) |=> wake_pulse && wake_src == 9'h001 && !slp;
    endproperty
    a_btn_wake: assert property (p_btn_wake) else $error("button ignored");
endmodule : swel_core_props

bind swel_core swel_core_props u_props (
    .clk(clk), .rst(rst), .ce(ce), .pwrbtn_n(pwrbtn_n), .usb_on_standby(usb_on_standby),
    .sleep_s3_n(sleep_s3_n), .sleep_s4_n(sleep_s4_n), .sleep_s5_n(sleep_s5_n),
    .wake_pulse(wake_pulse), .wake_src(wake_src)
);

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import swel_pkg::*;
    logic              clk     = 1'b0;
    logic              rst     = 1'b1;
    logic [ADDR_W-1:0] addr    = 8'h00;
    logic [DATA_W-1:0] wr_data = 32'h0000_0000;
    logic              wr_en   = 1'b0;
    logic              rd_en   = 1'b0;
    logic              usb_sb  = 1'b0;
    logic              ce      = 1'b1;
    logic [NSRC-1:0]   act     = 9'h000;
    wire  [NSRC-1:0]   pins;
    wire  [DATA_W-1:0] rd_data;
    wire               s3_n, s4_n, s5_n, pulse, irq;
    wire  [NSRC-1:0]   src;
    logic [DATA_W-1:0] d;
    logic [INT_W-1:0]  exp_int, mask;
    logic [EN_W-1:0]   en;
    logic              w;
    logic [2:0]        exp_pins;
    logic [NSRC-1:0]   exp_src = 9'h000;
    int                failures  = 0;
    int                tests_run = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    swel_core uut (
        .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .pwrbtn_n(pins[0]), .smb_alert_n(pins[1]),
        .pcie_wake_n(pins[2]), .wdt_pwrbtn(pins[3]), .gen_wake_n(pins[4]), .pme_n(pins[5]),
        .lan_wake(pins[6]), .usb_wake(pins[7]), .rtc_alarm(pins[8]), .usb_on_standby(usb_sb),
        .sleep_s3_n(s3_n), .sleep_s4_n(s4_n), .sleep_s5_n(s5_n), .wake_pulse(pulse),
        .wake_src(src), .irq(irq)
    );
    swel_wake_src u_src (.act(act), .pins(pins));

    task automatic check(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask : rd

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // whether source s wakes from state code st
    function automatic logic wakes(int s, int st, logic [EN_W-1:0] e, logic sb);
        if (st == 0) return 1'b0;
        case (s)
            4: return st == 1;
            5: return e[1] | e[2];
            6: return e[0];
            7: return e[3] & e[4] & (st == 2 | (st == 1 & sb));
            8: return e[5] & e[6] & st == 3;
            default: return 1'b1;
        endcase
    endfunction : wakes

    // main sequence: every source against every state, enables none, all, random
    initial begin
        void'($urandom(69990));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), d);
            check(d === 32'h0000_0000, "reset value or unmapped read");
        end
        for (int r = 0; r < 3; r++)
            for (int st = 0; st < 4; st++)
                for (int s = 0; s < NSRC; s++) begin
                    en = (r == 0) ? 7'h00 : (r == 1) ? 7'h7F : 7'($urandom);
                    mask = 10'($urandom);
                    usb_sb <= 1'($urandom);
                    wr(OFS_ENABLE, {25'h0, en});
                    wr(OFS_INT_MASK, {22'h0, mask});
                    rd(OFS_ENABLE, d);
                    check(d === {25'h0, en}, "enable readback");
                    exp_int = (st == 0) ? 10'h000 : 10'h200;
                    exp_pins = (st == 0) ? 3'h7 : ~(3'h1 << (st - 1));
                    wr(OFS_CTRL, 32'(st));
                    #1;
                    check({s5_n, s4_n, s3_n} === exp_pins, "state");
                    check(irq === |(exp_int & mask), "irq on sleep entry");
                    // a second sleep request while asleep must be ignored
                    if (st != 0)
                        wr(OFS_CTRL, 32'(st % 3 + 1));
                    rd(OFS_CTRL, d);
                    check(d === 32'(st), "state code");
                    w = wakes(s, st, en, usb_sb);
                    @(posedge clk);
                    act[s] <= 1'b1;
                    @(posedge clk);
                    #1;
                    if (s < 5)
                        check(pulse === w, "wake decision");
                    else if (s < 7)
                        check(pulse === w, "wake decision");
                    else
                        check(pulse === w, "wake decision");
                    if (w) begin
                        exp_src = 9'h001 << s;
                        check({s5_n, s4_n, s3_n, src} === {3'h7, exp_src}, "source");
                        exp_int[s] = 1'b1;
                    end else if (st != 0) begin
                        @(posedge clk);
                        act[0] <= 1'b1;
                        @(posedge clk);
                        #1;
                        check({pulse, src} === {1'b1, 9'h001}, "button wake");
                        exp_src = 9'h001;
                        exp_int[0] = 1'b1;
                    end
                    check(irq === |(exp_int & mask), "irq on wake");
                    // status shows working, the last source and the asserted levels
                    rd(OFS_STATUS, d);
                    check(d === {7'h0, act, 3'h0, exp_src, 4'h0}, "status");
                    @(posedge clk);
                    act <= 9'h000;
                    rd(OFS_INT_STAT, d);
                    check(d === {22'h0, exp_int}, "interrupt status");
                    check(irq === 1'b0, "irq after read clear");
                end
        // a low clock enable drops a write; read data last one cycle only
        @(posedge clk);
        ce <= 1'b0;
        wr(OFS_INT_MASK, {22'h0, ~mask});
        ce <= 1'b1;
        rd(OFS_INT_MASK, d);
        check(d === {22'h0, mask}, "write under clock enable low");
        @(posedge clk);
        #1;
        check(rd_data === 32'h0000_0000, "read data held too long");
        // reset in the middle of a sleep returns everything to working
        wr(OFS_CTRL, 32'h0000_0002);
        #1;
        check(s4_n === 1'b0, "sleep before reset");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({s5_n, s4_n, s3_n, pulse, irq, src} === 14'h3800, "mid-run reset");
        rd(OFS_INT_MASK, d);
        check(d === 32'h0000_0000, "mask after reset");
        finish_test();
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule : testbench
